// [logic/bcwd_defines.svh]
// offsets, field positions, reset values and limits of the window decode
`ifndef BCWD_DEFINES_SVH
`define BCWD_DEFINES_SVH
`define BCWD_SEL_OFF 8'h54
`define BCWD_MAX_CHANNEL_COUNT_OFF 8'h56
`define BCWD_MAXMOD_OFF 8'h57
`define BCWD_SEL_RESET 16'h0000
`define BCWD_SEL_WMASK 16'h01ff
`define BCWD_MAX_CHANNEL_COUNT_VAL 8'h04
`define BCWD_MAXMOD_VAL 8'h04
`define BCWD_CH_HI 8
`define BCWD_CH_LO 7
`define BCWD_SLOT_HI 6
`define BCWD_SLOT_LO 3
`define BCWD_FN_HI 2
`define BCWD_FN_LO 0
`define BCWD_LIMITED_TOP 4'h7
`define BCWD_NUM_SLOTS 64
`endif

// [logic/bcwd_pkg.sv]
// types shared by the buffer config window decode
package bcwd_pkg;
    typedef enum logic [1:0] {
        BCWD_SRC_FSB,
        BCWD_SRC_SMBUS,
        BCWD_SRC_JTAG
    } bcwd_src_t;

    typedef struct packed {
        logic [1:0] channel;
        logic [3:0] slot;
        logic [2:0] func;
        logic [7:0] offset;
        logic write;
        logic [31:0] data;
    } bcwd_cmd_t;
endpackage : bcwd_pkg

// [logic/bcwd_window_decode.sv]
// buffer configuration region and switching window decode
//
// Summary of operation
// - select register bits 8:7 pick the channel for the switching window
// - select register bits 6:3 pick the buffer slot for the window
// - select register bits 2:0 pick the buffer function for the window
// - channel count register is read-only and returns four
// - modules-per-channel register is read-only and returns four
// - the module limit applies only to slot codes 0 through 7
// - the region splits into 2 KB blocks, one buffer each
// - region hits become channel commands, gated by buffer presence
// - low 11 offset bits are function (3) then register offset (8)
// - offset bits 16:15 select channel, 32 KB per channel
// - offset bits 14:11 select slot 0 to F in 2 KB steps
// - absent buffers never receive a configuration command
// - window answers only SMBus and JTAG; processor bus is aborted except when a region hit makes the window busy
`include "bcwd_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module bcwd_window_decode (
    input wire logic clk_in,                     // 20 MHz core clock
    input wire logic reset_in,                   // async, active high
    input wire logic cfg_req_in,                 // config register access
    input wire logic cfg_write_in,               // 1 write, 0 read
    input wire logic [7:0] cfg_addr_in,          // dword aligned offset
    input wire logic [3:0] cfg_be_in,            // byte enables
    input wire logic [31:0] cfg_wdata_in,        // write data
    output logic cfg_ack_out,                    // access done pulse
    output logic [31:0] cfg_rdata_out,           // read data
    input wire logic [39:17] buffer_region_base_in, // region base
    input wire logic [63:0] buffer_present_mask_in, // ch*16+slot
    input wire logic mm_req_in,                  // memory access request
    input wire logic [39:0] mm_addr_in,          // byte address
    input wire logic mm_write_in,                // 1 write
    input wire logic [31:0] mm_wdata_in,         // write data
    input wire logic win_req_in,                 // window function access
    input wire bcwd_pkg::bcwd_src_t win_src_in,  // access origin
    input wire logic [7:0] win_offset_in,        // register offset
    input wire logic win_write_in,               // 1 write
    input wire logic [31:0] win_wdata_in,        // write data
    output logic win_busy_out,                   // window request refused
    output logic cmd_valid_out,                  // channel command pulse
    output bcwd_pkg::bcwd_cmd_t cmd_out,         // channel command
    output logic drop_out,                       // suppressed access pulse
    output logic abort_out                       // master abort pulse
);
    logic [15:0] sel_q;
    logic [15:0] sel_wr;
    logic [31:0] rd_d;
    logic mm_hit;
    logic [1:0] mm_ch;
    logic [3:0] mm_slot;
    logic [2:0] mm_fn;
    logic [5:0] mm_idx;
    logic [5:0] win_idx;
    logic win_take;
    logic slot_ok_mm;
    logic slot_ok_win;
    logic go_mm;
    logic go_win;
    logic [1:0] win_ch;
    logic [3:0] win_slot;

    // ------------------------------------------------------------------
    // select register and read path
    // ------------------------------------------------------------------
    always_comb begin
        sel_wr = sel_q;
        if (cfg_be_in[0]) begin
            sel_wr[7:0] = cfg_wdata_in[7:0];
        end
        if (cfg_be_in[1]) begin
            sel_wr[15:8] = cfg_wdata_in[15:8];
        end
        sel_wr = sel_wr & `BCWD_SEL_WMASK;
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            sel_q <= `BCWD_SEL_RESET;
        end else if (cfg_req_in && cfg_write_in &&
                     cfg_addr_in[7:2] == `BCWD_SEL_OFF >> 2) begin
            sel_q <= sel_wr;
        end
    end

    always_comb begin
        rd_d = 32'h0000_0000;
        if (cfg_addr_in[7:2] == `BCWD_SEL_OFF >> 2) begin
            rd_d = {`BCWD_MAXMOD_VAL, `BCWD_MAX_CHANNEL_COUNT_VAL, sel_q};
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            cfg_ack_out <= 1'b0;
            cfg_rdata_out <= 32'h0000_0000;
        end else begin
            cfg_ack_out <= cfg_req_in;
            if (cfg_req_in && !cfg_write_in) begin
                cfg_rdata_out <= rd_d;
            end
        end
    end

    // ------------------------------------------------------------------
    // region and window decode
    // ------------------------------------------------------------------
    assign mm_hit = mm_req_in && mm_addr_in[39:17] == buffer_region_base_in;
    assign mm_ch = mm_addr_in[16:15];
    assign mm_slot = mm_addr_in[14:11];
    assign mm_fn = mm_addr_in[10:8];
    assign mm_idx = {mm_ch, mm_slot};
    assign win_ch = sel_q[`BCWD_CH_HI:`BCWD_CH_LO];
    assign win_slot = sel_q[`BCWD_SLOT_HI:`BCWD_SLOT_LO];
    assign win_idx = {win_ch, win_slot};
    // slots 0-7 beyond the module count are unsupported
    assign slot_ok_mm = mm_slot > `BCWD_LIMITED_TOP ||
        {4'h0, mm_slot} < `BCWD_MAXMOD_VAL;
    assign slot_ok_win = win_slot > `BCWD_LIMITED_TOP ||
        {4'h0, win_slot} < `BCWD_MAXMOD_VAL;
    assign win_busy_out = win_req_in && mm_hit;
    assign win_take = win_req_in && !mm_hit;
    assign go_mm = mm_hit && buffer_present_mask_in[mm_idx] &&
        slot_ok_mm;
    assign go_win = win_take && win_src_in != bcwd_pkg::BCWD_SRC_FSB &&
        buffer_present_mask_in[win_idx] && slot_ok_win;

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            cmd_valid_out <= 1'b0;
            drop_out <= 1'b0;
            abort_out <= 1'b0;
        end else begin
            cmd_valid_out <= go_mm || go_win;
            abort_out <= win_take && win_src_in == bcwd_pkg::BCWD_SRC_FSB;
            drop_out <= (mm_hit && !go_mm) ||
                (win_take && win_src_in != bcwd_pkg::BCWD_SRC_FSB && !go_win);
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            cmd_out <= '0;
        end else if (go_mm) begin
            cmd_out <= {mm_ch, mm_slot, mm_fn, mm_addr_in[7:0],
                        mm_write_in, mm_wdata_in};
        end else if (go_win) begin
            cmd_out <= {win_ch, win_slot, sel_q[`BCWD_FN_HI:`BCWD_FN_LO],
                        win_offset_in, win_write_in, win_wdata_in};
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    a_sel_reserved_zero: assert property (sel_q[15:9] == 7'h00)
        else $error("select reserved bits not zero");
    a_sel_write_lands: assert property (cfg_req_in && cfg_write_in &&
        cfg_addr_in == `BCWD_SEL_OFF && cfg_be_in[1:0] == 2'b11 |=>
        sel_q == ($past(cfg_wdata_in[15:0]) & 16'h01ff))
        else $error("select write not stored");
    a_ro_counts: assert property (cfg_req_in && !cfg_write_in &&
        cfg_addr_in == `BCWD_SEL_OFF |=> cfg_ack_out &&
        cfg_rdata_out[31:16] == 16'h0404)
        else $error("capacity registers wrong");
    a_mm_chan_map: assert property (go_mm |=> cmd_valid_out &&
        cmd_out.channel == $past(mm_addr_in[16:15]) &&
        cmd_out.slot == $past(mm_addr_in[14:11]))
        else $error("region channel or slot wrong");
    a_mm_fn_off: assert property (go_mm |=> {cmd_out.func, cmd_out.offset}
        == $past(mm_addr_in[10:0]))
        else $error("region function or offset wrong");
    a_absent_no_cmd: assert property (mm_hit && !buffer_present_mask_in[mm_idx]
        |=> drop_out)
        else $error("absent buffer got a command");
    a_fsb_abort: assert property (win_take &&
        win_src_in == bcwd_pkg::BCWD_SRC_FSB |=> abort_out && !cmd_valid_out)
        else $error("processor window access not aborted");
    a_win_target: assert property (go_win |=> cmd_out.channel ==
        $past(sel_q[8:7]) && cmd_out.slot == $past(sel_q[6:3]) &&
        cmd_out.func == $past(sel_q[2:0]))
        else $error("window target wrong");
    a_limit_low_slots: assert property (mm_hit && mm_slot == 4'h5 |=>
        !cmd_valid_out)
        else $error("slot over module limit accepted");
    a_high_slot_ok: assert property (mm_hit && mm_slot == 4'hf &&
        buffer_present_mask_in[mm_idx] |=> cmd_valid_out)
        else $error("high slot not forwarded");

    c_mm_cmd: cover property (go_mm ##1 cmd_valid_out);
    c_win_cmd: cover property (go_win ##1 cmd_valid_out);
    c_abort: cover property (abort_out);
    c_drop: cover property (drop_out);
endmodule : bcwd_window_decode
`default_nettype wire

// [dv/bcwd_buffer_model.sv]
// buffer chip side: takes channel commands, counts bad targets
`timescale 1ns/1ns
`default_nettype none
module bcwd_buffer_model (
    input wire logic clk_in,                 // core clock
    input wire logic reset_in,               // async reset, active high
    input wire logic cmd_valid_in,           // command pulse
    input wire bcwd_pkg::bcwd_cmd_t cmd_in,  // channel command
    input wire logic [63:0] present_in,      // presence, ch*16+slot
    output int bad_out,                      // commands to forbidden slots
    output int seen_out                      // commands taken
);
    logic [5:0] idx;
    assign idx = {cmd_in.channel, cmd_in.slot};
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            bad_out <= 0;
            seen_out <= 0;
        end else if (cmd_valid_in) begin
            seen_out <= seen_out + 1;
            // absent slot or over the module limit is never addressed
            if (!present_in[idx] || cmd_in.slot[3:2] == 2'h1) begin
                bad_out <= bad_out + 1;
            end
        end
    end
endmodule : bcwd_buffer_model
`default_nettype wire

// [dv/bcwd_window_decode_tb.sv]
// self-checking bench for the buffer config window decode
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
    n_mismatch++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module bcwd_window_decode_tb;
    logic clk_in = 0, reset_in = 1, cfg_req_in = 0, cfg_write_in = 0;
    logic [7:0] cfg_addr_in = 0, win_offset_in = 0;
    logic [3:0] cfg_be_in = 0;
    logic [31:0] cfg_wdata_in = 0, mm_wdata_in = 0, win_wdata_in = 0;
    logic [39:17] buffer_region_base_in = 0;
    logic [63:0] buffer_present_mask_in = 0;
    logic mm_req_in = 0, mm_write_in = 0, win_req_in = 0, win_write_in = 0;
    logic [39:0] mm_addr_in = 0;
    bcwd_pkg::bcwd_src_t win_src_in = bcwd_pkg::BCWD_SRC_FSB;
    logic cfg_ack_out, win_busy_out, cmd_valid_out, drop_out, abort_out;
    logic [31:0] cfg_rdata_out;
    bcwd_pkg::bcwd_cmd_t cmd_out, e;
    logic [15:0] sel_m = 0;
    logic [16:0] corner [4] = '{17'h07800, 17'h08000, 17'h18000, 17'h1ffff};
    int n_mismatch = 0, tests_run = 0, n_cmd = 0, bad, seen;
    always #25 clk_in = ~clk_in;
    bcwd_window_decode uut (.*);
    bcwd_buffer_model partner (.clk_in(clk_in), .reset_in(reset_in),
        .cmd_valid_in(cmd_valid_out), .cmd_in(cmd_out),
        .present_in(buffer_present_mask_in), .bad_out(bad), .seen_out(seen));
    task final_report();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : final_report
    task cfg(input logic w, input logic [7:0] a, input logic [3:0] be,
             input logic [31:0] d);
        @(posedge clk_in);
        {cfg_req_in, cfg_write_in, cfg_addr_in} <= {1'b1, w, a};
        {cfg_be_in, cfg_wdata_in} <= {be, d};
        @(posedge clk_in);
        cfg_req_in <= 0;
        #1;
        `CHK("ack", 1'b1, cfg_ack_out)
        if (w && a == 8'h54) begin
            if (be[0]) sel_m[7:0] = d[7:0];
            if (be[1]) sel_m[15:8] = d[15:8] & 8'h01;
        end else if (!w) begin
            e = (a == 8'h54) ? {8'h04, 8'h04, sel_m} : 32'h0;
            `CHK("rdata", e[31:0], cfg_rdata_out)
        end
    endtask : cfg
    task acc(input logic mm, input logic wn, input logic miss,
             input logic [16:0] off, input logic [1:0] src);
        logic hit, ab, iss, ok;
        hit = mm && !miss;
        ab = wn && !hit && src == 2'h0;
        iss = hit || (wn && !hit && src != 2'h0);
        e.write = $urandom;
        e.data = $urandom;
        @(posedge clk_in);
        {mm_req_in, win_req_in, mm_write_in, win_write_in} <= {mm, wn,
            e.write, e.write};
        {mm_wdata_in, win_wdata_in, win_offset_in} <= {e.data, e.data, off[7:0]};
        mm_addr_in <= {buffer_region_base_in + miss, off};
        win_src_in <= bcwd_pkg::bcwd_src_t'(src);
        if (hit) {e.channel, e.slot, e.func, e.offset} = off;
        else {e.channel, e.slot, e.func, e.offset} = {sel_m[8:0], off[7:0]};
        ok = buffer_present_mask_in[{e.channel, e.slot}] && e.slot[3:2] != 2'h1;
        #1;
        `CHK("busy", hit && wn, win_busy_out)
        @(posedge clk_in);
        {mm_req_in, win_req_in} <= 2'b00;
        #1;
        `CHK("valid", iss && ok, cmd_valid_out)
        `CHK("drop", iss && !ok, drop_out)
        `CHK("abort", ab, abort_out)
        if (iss && ok) begin
            n_cmd++;
            `CHK("cmd", e, cmd_out)
        end
    endtask : acc
    initial begin
        #2000000;
        n_mismatch++;
        final_report();
    end
    initial begin
        void'($urandom(32'hbf468573));
        buffer_region_base_in <= $urandom;
        buffer_present_mask_in <= {$urandom, $urandom};
        repeat (3) @(posedge clk_in);
        reset_in <= 0;
        cfg(0, 8'h54, 4'hf, 0);
        cfg(1, 8'h54, 4'h3, 32'hffffffff);
        cfg(0, 8'h54, 4'h0, 0);
        cfg(0, 8'h58, 4'h0, 0);
        foreach (corner[i]) acc(1, 0, 0, corner[i], 0);
        acc(1, 1, 1, 17'h0, 1);
        repeat (80) begin
            cfg(1, 8'h54, 4'($urandom), $urandom);
            cfg(0, 8'h54, 4'h0, 0);
            for (int s = 0; s < 3; s++) acc(0, 1, 0, 17'($urandom), 2'(s));
            acc(1, 1'($urandom), 1'($urandom), 17'($urandom), 1);
        end
        `CHK("partner bad", 0, bad)
        `CHK("partner seen", n_cmd, seen)
        final_report();
    end
endmodule : bcwd_window_decode_tb
`default_nettype wire
